// [umst_top.sv]
// Modem-status tracking of one UART channel behind an APB slave
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "umst_map.svh"
module umst_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_load,
    input wire logic [7:0] rx_data,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic dcd_n,
    output logic dtr_n,
    output logic rts_n,
    output logic user_output_one_n,
    output logic user_output_two_n,
    output logic modem_irq
);
    import umst_pkg::*;

    umst_state_t state_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_mux;
    logic [`UMST_MC_MSB:0] mod_ctrl_reg;
    logic [7:0] rx_hold_reg;
    logic rx_avail_reg;
    umst_lines_t prev_reg;
    umst_lines_t flags_reg;
    umst_lines_t flags_next;
    umst_lines_t sel_level;
    umst_lines_t loop_level;
    umst_lines_t chg_vec;
    umst_lines_t clr_mask;
    logic modem_irq_reg;
    logic dtr_n_reg;
    logic rts_n_reg;
    logic user_output_one_n_reg;
    logic user_output_two_n_reg;
    logic loop_on;
    logic [5:0] idx;
    logic aligned;
    logic hit_rx_hold;
    logic hit_mod_ctrl;
    logic hit_line_st;
    logic hit_modem_st;
    logic mapped;
    logic acc_first;
    logic acc_done;
    logic rd_modem_done;
    logic rd_rx_done;
    logic [1:0] age_reg;

    umst_sync_if lines_if ();

    // Pins go through the synchroniser before any edge check
    assign lines_if.pins_n = {dcd_n, ri_n, dsr_n, cts_n};

    umst_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .lines(lines_if.sync_side)
    );

    // Address decode; unaligned addresses count as unmapped
    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == `UMST_ALIGN_OK);
    assign hit_rx_hold = aligned && (idx == `UMST_IDX_RX_HOLD);
    assign hit_mod_ctrl = aligned && (idx == `UMST_IDX_MOD_CTRL);
    assign hit_line_st = aligned && (idx == `UMST_IDX_LINE_ST);
    assign hit_modem_st = aligned && (idx == `UMST_IDX_MODEM_ST);
    assign mapped = hit_rx_hold || hit_mod_ctrl || hit_line_st || hit_modem_st;

    // First access cycle latches data, the second one completes
    assign acc_first = psel && penable && (state_reg == UMST_ST_IDLE);
    assign acc_done = psel && penable && pready_reg;
    assign rd_modem_done = acc_done && !pwrite && hit_modem_st;
    assign rd_rx_done = acc_done && !pwrite && hit_rx_hold;

    // Slave phase: always one wait state, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= UMST_ST_IDLE;
            pready_reg <= 1'b0;
        end else begin
            case (state_reg)
                UMST_ST_IDLE: begin
                    if (psel && penable) begin
                        state_reg <= UMST_ST_DONE;
                        pready_reg <= 1'b1;
                    end
                end
                UMST_ST_DONE: begin
                    state_reg <= UMST_ST_IDLE;
                    pready_reg <= 1'b0;
                end
                default: begin
                    state_reg <= UMST_ST_IDLE;
                    pready_reg <= 1'b0;
                end
            endcase
        end
    end

    // Error answer for any address outside the map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (acc_first) begin
            pslverr_reg <= !mapped;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // Loopback feeds the channel's own control bits back in
    assign loop_on = mod_ctrl_reg[`UMST_MC_LOOP];
    assign loop_level[`UMST_LN_CTS] = mod_ctrl_reg[`UMST_MC_RTS];
    assign loop_level[`UMST_LN_DSR] = mod_ctrl_reg[`UMST_MC_DTR];
    assign loop_level[`UMST_LN_RI] = mod_ctrl_reg[`UMST_MC_USER_OUTPUT_ONE];
    assign loop_level[`UMST_LN_DCD] = mod_ctrl_reg[`UMST_MC_USER_OUTPUT_TWO];
    // Pin levels are already complemented by the synchroniser
    assign sel_level = loop_on ? loop_level : lines_if.level;

    // Read data, built from current state in the first access cycle
    always_comb begin
        rd_mux = `UMST_WORD_RESET;
        if (hit_rx_hold) begin
            rd_mux[7:0] = rx_hold_reg;
        end else if (hit_mod_ctrl) begin
            rd_mux[`UMST_MC_MSB:0] = mod_ctrl_reg;
        end else if (hit_line_st) begin
            rd_mux[`UMST_LS_RX_AVAIL] = rx_avail_reg;
        end else if (hit_modem_st) begin
            rd_mux[7:0] = {sel_level, flags_reg};
        end
    end

    // Read data held until the next read; zero on unmapped reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= `UMST_WORD_RESET;
        end else if (acc_first && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // Control register written at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_ctrl_reg <= `UMST_MC_RESET;
        end else if (acc_done && pwrite && hit_mod_ctrl) begin
            mod_ctrl_reg <= pwdata[`UMST_MC_MSB:0];
        end
    end

    // Control pins are active low; loopback parks them inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtr_n_reg <= 1'b1;
            rts_n_reg <= 1'b1;
            user_output_one_n_reg <= 1'b1;
            user_output_two_n_reg <= 1'b1;
        end else begin
            dtr_n_reg <= loop_on || !mod_ctrl_reg[`UMST_MC_DTR];
            rts_n_reg <= loop_on || !mod_ctrl_reg[`UMST_MC_RTS];
            user_output_one_n_reg <= loop_on || !mod_ctrl_reg[`UMST_MC_USER_OUTPUT_ONE];
            user_output_two_n_reg <= loop_on || !mod_ctrl_reg[`UMST_MC_USER_OUTPUT_TWO];
        end
    end

    // Receive holding word; a new load overwrites an unread one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_reg <= `UMST_BYTE_RESET;
        end else if (rx_load) begin
            rx_hold_reg <= rx_data;
        end
    end

    // Char-available: a load in the reading cycle keeps it set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_avail_reg <= 1'b0;
        end else if (rx_load) begin
            rx_avail_reg <= 1'b1;
        end else if (rd_rx_done) begin
            rx_avail_reg <= 1'b0;
        end
    end

    // Last seen level of each line, for edge checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= `UMST_LINES_RESET;
        end else begin
            prev_reg <= sel_level;
        end
    end

    // Level changes; ring counts only its pin rising 0 to 1
    assign chg_vec[`UMST_LN_CTS] = sel_level[`UMST_LN_CTS] ^ prev_reg[`UMST_LN_CTS];
    assign chg_vec[`UMST_LN_DSR] = sel_level[`UMST_LN_DSR] ^ prev_reg[`UMST_LN_DSR];
    assign chg_vec[`UMST_LN_RI] = prev_reg[`UMST_LN_RI] && !sel_level[`UMST_LN_RI];
    assign chg_vec[`UMST_LN_DCD] = sel_level[`UMST_LN_DCD] ^ prev_reg[`UMST_LN_DCD];

    // Clear only the bits the host actually saw, so nothing is lost
    assign clr_mask = rd_modem_done ? prdata_reg[3:0] : `UMST_LINES_RESET;
    // Set wins over clear
    assign flags_next = (flags_reg & ~clr_mask) | chg_vec;

    // Sticky change flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `UMST_LINES_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Interrupt is a registered OR of the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_irq_reg <= 1'b0;
        end else begin
            modem_irq_reg <= |flags_reg;
        end
    end

    // Cycles since reset, so pin history checks skip reset time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= 2'h0;
        end else if (age_reg != `UMST_AGE_FULL) begin
            age_reg <= age_reg + `UMST_AGE_STEP;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign dtr_n = dtr_n_reg;
    assign rts_n = rts_n_reg;
    assign user_output_one_n = user_output_one_n_reg;
    assign user_output_two_n = user_output_two_n_reg;
    assign modem_irq = modem_irq_reg;

    // Checks on the design's own behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_msr_setup;
        psel && !penable && !pwrite && hit_modem_st;
    endsequence

    sequence s_msr_quiet_access;
        (psel && penable && (chg_vec == 4'h0))[*2];
    endsequence

    sequence s_msr_first;
        acc_first && !pwrite && hit_modem_st;
    endsequence

    property p_rx_set;
        rx_load |=> rx_avail_reg;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("char-available not set");

    property p_rx_clear;
        rd_rx_done && !rx_load |=> !rx_avail_reg ##1 !rx_avail_reg || $past(rx_load);
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("char-available not cleared");

    property p_flag_set;
        (chg_vec != 4'h0) |=> ((flags_reg & $past(chg_vec)) == $past(chg_vec));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change flag missed");

    property p_msr_clear;
        s_msr_setup ##1 s_msr_quiet_access |=> (flags_reg == 4'h0);
    endproperty
    a_msr_clear: assert property (p_msr_clear) else $error("flags not cleared by read");

    property p_dcd_pin;
        (age_reg == `UMST_AGE_FULL) && !loop_on |-> sel_level[3] == !$past(dcd_n, 2);
    endproperty
    a_dcd_pin: assert property (p_dcd_pin) else $error("carrier level wrong");

    property p_ri_loop;
        (s_msr_first and loop_on) |=> prdata_reg[6] == $past(mod_ctrl_reg[2]);
    endproperty
    a_ri_loop: assert property (p_ri_loop) else $error("ring loopback wrong");

    property p_dsr_pin;
        ((age_reg == `UMST_AGE_FULL) and s_msr_first and !loop_on)
            |=> prdata_reg[5] == !$past(dsr_n, 3);
    endproperty
    a_dsr_pin: assert property (p_dsr_pin) else $error("set-ready level wrong");

    property p_cts_loop;
        (s_msr_first and loop_on) |=> prdata_reg[4] == $past(mod_ctrl_reg[1]);
    endproperty
    a_cts_loop: assert property (p_cts_loop) else $error("clear-send loopback wrong");

    property p_ri_edge;
        $fell(sel_level[2]) |=> flags_reg[2];
    endproperty
    a_ri_edge: assert property (p_ri_edge) else $error("ring edge missed");

    property p_ri_rise_ignored;
        $rose(sel_level[2]) && !flags_reg[2] |=> !flags_reg[2];
    endproperty
    a_ri_rise_ignored: assert property (p_ri_rise_ignored) else $error("ring wrong edge");

    property p_irq;
        (flags_reg != 4'h0) |=> modem_irq ##1 1'b1;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_irq_quiet;
        (flags_reg == 4'h0) |=> !modem_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

    property p_read_race;
        rd_modem_done && chg_vec[0] |=> flags_reg[0];
    endproperty
    a_read_race: assert property (p_read_race) else $error("change lost during read");

    property p_one_wait;
        acc_first |=> pready ##1 !pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer timing wrong");
endmodule // umst_top

// [umst_map.svh]
// Register indices, field positions and reset values of the modem-status block
`ifndef UMST_MAP_SVH
`define UMST_MAP_SVH

// Register indices; byte address is four times the index
`define UMST_IDX_RX_HOLD 6'h00
`define UMST_IDX_MOD_CTRL 6'h04
`define UMST_IDX_LINE_ST 6'h05
`define UMST_IDX_MODEM_ST 6'h06

// Word alignment of the byte address
`define UMST_ALIGN_OK 2'h0

// Field positions in modem_output_control
`define UMST_MC_DTR 0
`define UMST_MC_RTS 1
`define UMST_MC_USER_OUTPUT_ONE 2
`define UMST_MC_USER_OUTPUT_TWO 3
`define UMST_MC_LOOP 4
`define UMST_MC_MSB 4

// Field positions in the line-state register
`define UMST_LS_RX_AVAIL 0

// Line vector slots; same order as the change flags in modem_line_state
`define UMST_LN_CTS 0
`define UMST_LN_DSR 1
`define UMST_LN_RI 2
`define UMST_LN_DCD 3

// Reset values, and the age counter's limit and step
`define UMST_MC_RESET 5'h00
`define UMST_PINS_IDLE 4'hf
`define UMST_LINES_RESET 4'h0
`define UMST_BYTE_RESET 8'h00
`define UMST_WORD_RESET 32'h0000_0000
`define UMST_AGE_FULL 2'h3
`define UMST_AGE_STEP 2'h1

`endif

// [umst_pkg.sv]
// Types shared by the modem-status block
package umst_pkg;
    // One bit per modem line, slot order cts, dsr, ri, dcd
    typedef logic [3:0] umst_lines_t;
    // Bus slave phase, one-hot
    typedef enum logic [1:0] {
        UMST_ST_IDLE = 2'b01,
        UMST_ST_DONE = 2'b10
    } umst_state_t;
endpackage

// [umst_sync_if.sv]
// Raw modem pins in, synchronised active-high levels out
`timescale 1ns/1ps
interface umst_sync_if;
    umst_pkg::umst_lines_t pins_n;
    umst_pkg::umst_lines_t level;
    modport sync_side (input pins_n, output level);
    modport user (output pins_n, input level);
endinterface

// [umst_sync.sv]
// Two-flop synchroniser for the four modem input pins
`timescale 1ns/1ps
`include "umst_map.svh"
module umst_sync (
    input wire logic pclk,
    input wire logic presetn,
    umst_sync_if.sync_side lines
);
    import umst_pkg::*;

    umst_lines_t stage1_reg;
    umst_lines_t stage2_reg;

    // Pins idle high, so reset to the inactive level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= `UMST_PINS_IDLE;
            stage2_reg <= `UMST_PINS_IDLE;
        end else begin
            stage1_reg <= lines.pins_n;
            stage2_reg <= stage1_reg;
        end
    end

    // Complement of the settled pins
    assign lines.level = ~stage2_reg;
endmodule // umst_sync

// [umst_modem_model.sv]
// Behavioural modem that drives the four active-low modem status lines
`timescale 1ns/1ps
module umst_modem_model (
    input wire logic pclk,
    output umst_pkg::umst_lines_t lines_n
);
    import umst_pkg::*;

    // Lines rest high, as a modem with pull-ups and nothing asserted
    initial begin
        lines_n = 4'hf;
    end

    // New levels land just after an edge, so no sample races the change
    task automatic set_lines(input umst_lines_t v);
        @(posedge pclk);
        lines_n <= v;
    endtask
endmodule // umst_modem_model

// [tb.sv]
// Self-checking bench for the modem-status block
`timescale 1ns/1ps
`include "umst_map.svh"
module tb;
    import umst_pkg::*;

    localparam logic [7:0] A_RX = {`UMST_IDX_RX_HOLD, 2'h0};
    localparam logic [7:0] A_MC = {`UMST_IDX_MOD_CTRL, 2'h0};
    localparam logic [7:0] A_LS = {`UMST_IDX_LINE_ST, 2'h0};
    localparam logic [7:0] A_MS = {`UMST_IDX_MODEM_ST, 2'h0};
    // Status bit fed by control bits dtr, rts, user one, user two in loopback
    localparam logic [31:0] LOOP_BIT [4] = '{32'h20, 32'h10, 32'h40, 32'h80};

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_load;
    logic [7:0] rx_data;
    umst_lines_t lines_n;
    logic dtr_n;
    logic rts_n;
    logic user_output_one_n;
    logic user_output_two_n;
    logic modem_irq;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int check_count = 0;

    umst_top i_umst_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_load(rx_load), .rx_data(rx_data),
        .cts_n(lines_n[`UMST_LN_CTS]), .dsr_n(lines_n[`UMST_LN_DSR]),
        .ri_n(lines_n[`UMST_LN_RI]), .dcd_n(lines_n[`UMST_LN_DCD]),
        .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
        .modem_irq(modem_irq)
    );

    umst_modem_model i_umst_modem_model (
        .pclk(pclk),
        .lines_n(lines_n)
    );

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; the wait is bounded so a dead slave cannot hang us
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("ERROR pready expected 1 seen 0");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic t_reset;
        apb(1'b0, A_MS, 32'h0);
        check("status after reset", rd, 32'h0);
        check("irq after reset", 32'(modem_irq), 32'h0);
        check("outputs after reset", 32'({dtr_n, rts_n, user_output_one_n, user_output_two_n}), 32'hf);
    endtask

    // Each line dropped then raised; ring flags only on the pin rising
    task automatic t_lines;
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            i_umst_modem_model.set_lines(4'hf & ~(4'h1 << i));
            repeat (6) @(posedge pclk);
            e = (32'h10 << i) | ((i == `UMST_LN_RI) ? 32'h0 : (32'h1 << i));
            check("irq after fall", 32'(modem_irq), 32'(e[3:0] != 4'h0));
            apb(1'b0, A_MS, 32'h0);
            check("status after fall", rd, e);
            apb(1'b0, A_MS, 32'h0);
            check("status reread", rd, 32'h10 << i);
            i_umst_modem_model.set_lines(4'hf);
            repeat (6) @(posedge pclk);
            check("irq after rise", 32'(modem_irq), 32'h1);
            apb(1'b0, A_MS, 32'h0);
            check("status after rise", rd, 32'h1 << i);
            apb(1'b0, A_MS, 32'h0);
            check("status cleared", rd, 32'h0);
            repeat (2) @(posedge pclk);
            check("irq after clear", 32'(modem_irq), 32'h0);
        end
    endtask

    // Pins held asserted during loopback must not reach the levels
    task automatic t_loop;
        i_umst_modem_model.set_lines(4'h0);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, A_MC, 32'h10 | (32'h1 << j));
            repeat (3) @(posedge pclk);
            check("parked outputs", 32'({dtr_n, rts_n, user_output_one_n, user_output_two_n}), 32'hf);
            apb(1'b0, A_MC, 32'h0);
            check("control readback", rd, 32'h10 | (32'h1 << j));
            apb(1'b0, A_MS, 32'h0);
            check("loopback level", rd & 32'hf0, LOOP_BIT[j]);
        end
        i_umst_modem_model.set_lines(4'hf);
        apb(1'b1, A_MC, 32'h0f);
        repeat (3) @(posedge pclk);
        check("driven outputs", 32'({dtr_n, rts_n, user_output_one_n, user_output_two_n}), 32'h0);
        apb(1'b1, A_MC, 32'h0);
        repeat (6) @(posedge pclk);
        apb(1'b0, A_MS, 32'h0);
        apb(1'b0, A_MS, 32'h0);
        check("status after loopback", rd, 32'h0);
    endtask

    task automatic t_rx;
        @(posedge pclk);
        rx_load <= 1'b1;
        rx_data <= 8'ha5;
        @(posedge pclk);
        rx_load <= 1'b0;
        apb(1'b0, A_LS, 32'h0);
        check("char available set", rd, 32'h1);
        apb(1'b0, A_RX, 32'h0);
        check("holding word", rd, 32'ha5);
        apb(1'b0, A_LS, 32'h0);
        check("char available clear", rd, 32'h0);
    endtask

    // Clear-send change lands on the clearing edge of a read; it must stay flagged
    task automatic t_race;
        fork
            i_umst_modem_model.set_lines(4'he);
            apb(1'b0, A_MS, 32'h0);
        join
        check("race snapshot", rd, 32'h0);
        apb(1'b0, A_MS, 32'h0);
        check("race flag kept", rd, 32'h11);
        apb(1'b0, A_MS, 32'h0);
        check("race flag cleared", rd, 32'h10);
        i_umst_modem_model.set_lines(4'hf);
        repeat (6) @(posedge pclk);
        apb(1'b0, A_MS, 32'h0);
        check("race release", rd, 32'h1);
    endtask

    // Unmapped, unaligned and read-only targets
    task automatic t_bad;
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, 8'h19, 32'hff);
        check("unaligned error", 32'(err), 32'h1);
        apb(1'b1, A_MS, 32'hff);
        check("read-only write error", 32'(err), 32'h0);
        apb(1'b0, A_MS, 32'h0);
        check("read-only unchanged", rd, 32'h0);
    endtask

    // Reset, then every scenario in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rx_load = 1'b0;
        rx_data = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lines();
        t_loop();
        t_rx();
        t_race();
        t_bad();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        summarize();
    end
endmodule // tb
